// ### logic/bus_options_pkg.sv
// shared types of the bus options register bank
`default_nettype none
package bus_options_pkg;
    typedef logic [3:0]  max_rec_t;
    typedef logic [1:0]  gen_t;
    typedef logic [7:0]  clk_acc_t;
    typedef logic [4:0]  cap_flags_t;
    typedef enum {ph_idle, ph_setup, ph_access} apb_phase_t;
endpackage
`default_nettype wire

// ### logic/bus_options_register.sv
// bus options register bank with apb access and bus information output
//
// Overview of operation
// R1 - the four capability flags in bits 31 to 28 are writable and software sets them before link activation.
// R2 - bit 27 is a writable flag advertising power management support when one.
// R3 - bits 26 to 24, 11 to 8 and 5 to 3 read as zero and ignore writes.
// R4 - bits 23 to 16 hold a writable cycle master clock accuracy in ppm.
// R5 - bits 15 to 12 code the maximum request bytes as two to code plus one, never below 512.
// R6 - hardware reset loads the code for 2048 bytes and software reset leaves it alone.
// R7 - software may rewrite the request code but keeps it valid while the link is active.
// R8 - a block write longer than the coded maximum may be answered with a type error ack.
// R9 - bits 7 and 6 are a writable generation counter stepped when the rom changed since bus reset.
// R10 - bits 2 to 0 read the fixed link speed code 010.
// R11 - the register is presented to the serial bus as the second bus information quadlet.
// R12 - the generation counter wraps from three to zero.
`include "bus_options_regs.svh"
`default_nettype none
module bus_options_register
    import bus_options_pkg::*;
#(
    parameter int LEN_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             rom_changed,
    input  wire logic             bus_reset,
    input  wire logic             blk_wr_valid,
    input  wire logic [LEN_W-1:0] blk_wr_len,
    output logic      [31:0]      bus_info_quadlet,
    output logic                  link_active_control,
    output logic                  ack_type_error
);

    cap_flags_t  flags_reg;
    cap_flags_t  flags_next;
    clk_acc_t    acc_reg;
    clk_acc_t    acc_next;
    max_rec_t    max_rec_reg;
    max_rec_t    max_rec_next;
    gen_t        gen_reg;
    gen_t        gen_next;
    gen_t        gen_base;
    logic        link_reg;
    logic        link_next;
    logic        pend_reg;
    logic        pend_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        err_reg;
    logic        err_next;

    apb_phase_t  phase;
    logic        setup;
    logic        access;
    logic        wr_en;
    logic        hit_opts;
    logic        hit_ctrl;
    logic        bad_addr;
    logic        wr_opts;
    logic        wr_ctrl;
    logic        soft_rst;
    logic        rec_legal;
    logic        rec_wr;
    logic        gen_inc;
    logic [31:0] opts_word;
    logic [31:0] ctrl_word;
    logic [31:0] rd_mux;
    max_rec_t    wr_code;

    // apb phase decode
    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign phase  = access ? ph_access : (setup ? ph_setup : ph_idle);
    assign wr_en  = access & pwrite;

    // address decode
    assign hit_opts = (paddr == `ADDR_BUS_OPTS);
    assign hit_ctrl = (paddr == `ADDR_LINK_CTRL);
    assign bad_addr = ~(hit_opts | hit_ctrl);
    assign wr_opts  = wr_en & hit_opts;
    assign wr_ctrl  = wr_en & hit_ctrl;
    assign soft_rst = wr_ctrl & pstrb[`LANE_CTRL] & pwdata[`CTRL_SRST_BIT];

    // capability flags and power management flag
    assign flags_next = soft_rst ? '0 :
                        (wr_opts & pstrb[`LANE_FLAGS]) ? pwdata[`FLAGS_MSB:`FLAGS_LSB] :
                        flags_reg; // R1 R2

    // clock accuracy
    assign acc_next = soft_rst ? '0 :
                      (wr_opts & pstrb[`LANE_ACC]) ? pwdata[`ACC_MSB:`ACC_LSB] :
                      acc_reg; // R4

    // request size code, codes under 512 bytes are refused, soft reset ignored
    assign wr_code      = pwdata[`MAXREC_MSB:`MAXREC_LSB];
    assign rec_legal    = (wr_code >= `MAXREC_MIN); // R5
    assign rec_wr       = wr_opts & pstrb[`LANE_MAXREC] & rec_legal; // R5
    assign max_rec_next = rec_wr ? wr_code : max_rec_reg; // R6 R7

    // generation counter, rom change pending until bus reset or software reset
    assign gen_inc   = bus_reset & pend_reg; // R9
    assign gen_base  = soft_rst ? `GEN_ZERO :
                       (wr_opts & pstrb[`LANE_GEN]) ? pwdata[`GEN_MSB:`GEN_LSB] :
                       gen_reg;
    assign gen_next  = gen_base + gen_t'(gen_inc); // R9 R12
    assign pend_next = rom_changed | (pend_reg & ~bus_reset & ~soft_rst); // R9

    // link active control
    assign link_next = soft_rst ? 1'b0 :
                       (wr_ctrl & pstrb[`LANE_CTRL]) ? pwdata[`CTRL_LINK_BIT] :
                       link_reg;

    // read words, reserved bits tied low
    assign opts_word = {flags_reg, 3'h0, acc_reg, max_rec_reg,
                        4'h0, gen_reg, 3'h0, `LINK_SPEED}; // R3 R10
    assign ctrl_word = (32'(link_reg) << `CTRL_LINK_BIT) |
                       (32'(pend_reg) << `CTRL_PEND_BIT);
    assign rd_mux    = hit_opts ? opts_word :
                       hit_ctrl ? ctrl_word :
                       32'h0000_0000;

    // read data and error captured in the setup cycle
    assign prdata_next = setup ? (pwrite ? 32'h0000_0000 : rd_mux) : prdata_reg;
    assign err_next    = setup ? bad_addr : err_reg;

    // apb answer, no wait states
    assign pready  = (phase == ph_access);
    assign pslverr = access & err_reg;
    assign prdata  = prdata_reg;

    // outputs toward the link and the serial bus
    assign bus_info_quadlet    = opts_word; // R11
    assign link_active_control = link_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg   <= '0;
            acc_reg     <= '0;
            max_rec_reg <= `MAXREC_RESET; // R6
            gen_reg     <= `GEN_ZERO;
            pend_reg    <= 1'b0;
            link_reg    <= 1'b0;
        end else begin
            flags_reg   <= flags_next;
            acc_reg     <= acc_next;
            max_rec_reg <= max_rec_next;
            gen_reg     <= gen_next;
            pend_reg    <= pend_next;
            link_reg    <= link_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            err_reg    <= err_next;
        end
    end

    // oversized write detection
    request_size_check #(
        .LEN_W (LEN_W)
    ) u_size_check (
        .pclk           (pclk),
        .presetn        (presetn),
        .max_rec        (max_rec_reg),
        .blk_wr_valid   (blk_wr_valid),
        .blk_wr_len     (blk_wr_len),
        .ack_type_error (ack_type_error)
    ); // R8

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_flags_write: assert property ( // R1
        wr_opts && pstrb[`LANE_FLAGS] && !soft_rst
        |=> bus_info_quadlet[31:28] == $past(pwdata[31:28]))
        else $error("capability flags not written");

    chk_pmc_write: assert property ( // R2
        wr_opts && pstrb[`LANE_FLAGS]
        |=> bus_info_quadlet[`PMC_BIT] == $past(pwdata[`PMC_BIT]))
        else $error("power management flag not written");

    chk_reserved_zero: assert property ( // R3
        (bus_info_quadlet & `RSVD_MASK) == 32'h0000_0000)
        else $error("reserved bits not zero");

    chk_reserved_read: assert property ( // R3
        setup && !pwrite && hit_opts
        |=> ((prdata & `RSVD_MASK) == 32'h0000_0000) && pready)
        else $error("reserved bits read back nonzero");

    chk_accuracy_hold: assert property ( // R4
        !(wr_opts && pstrb[`LANE_ACC]) && !soft_rst
        |=> $stable(bus_info_quadlet[`ACC_MSB:`ACC_LSB]))
        else $error("clock accuracy changed without a write");

    chk_maxrec_floor: assert property ( // R5
        bus_info_quadlet[`MAXREC_MSB:`MAXREC_LSB] >= `MAXREC_MIN)
        else $error("request size code below 512 bytes");

    chk_maxrec_refuse: assert property ( // R5
        wr_opts && pstrb[`LANE_MAXREC] && (wr_code < `MAXREC_MIN)
        |=> $stable(max_rec_reg))
        else $error("illegal request size code accepted");

    chk_soft_keeps_maxrec: assert property ( // R6
        soft_rst |=> $stable(max_rec_reg) ##1 (flags_reg == '0))
        else $error("software reset disturbed request size code");

    chk_gen_step: assert property ( // R9
        bus_reset && pend_reg && !wr_opts && !soft_rst
        |=> gen_reg == $past(gen_reg) + 2'h1)
        else $error("generation counter did not step");

    chk_gen_quiet: assert property ( // R9
        !bus_reset && !wr_opts && !soft_rst |=> $stable(gen_reg))
        else $error("generation counter moved without cause");

    chk_gen_wrap: assert property ( // R12
        gen_reg == 2'h3 && gen_inc && !wr_opts && !soft_rst |=> gen_reg == 2'h0)
        else $error("generation counter did not wrap");

    chk_link_speed: assert property ( // R10
        bus_info_quadlet[`SPD_MSB:`SPD_LSB] == `LINK_SPEED)
        else $error("link speed code wrong");

    chk_quadlet_readback: assert property ( // R11
        setup && !pwrite && hit_opts ##1 !$changed(bus_info_quadlet)
        |-> prdata == bus_info_quadlet)
        else $error("bus information quadlet differs from register read");

    chk_unmapped_error: assert property (
        setup && bad_addr |=> pslverr && pready)
        else $error("unmapped access not refused");

    chk_acc_write: assert property ( // R4
        wr_opts && pstrb[`LANE_ACC]
        |=> bus_info_quadlet[`ACC_MSB:`ACC_LSB] == $past(pwdata[`ACC_MSB:`ACC_LSB]))
        else $error("clock accuracy not written");

    chk_maxrec_take: assert property ( // R5
        wr_opts && pstrb[`LANE_MAXREC] && rec_legal |=> max_rec_reg == $past(wr_code))
        else $error("legal request size code not taken");

    chk_maxrec_hold: assert property ( // R6
        !rec_wr |=> $stable(max_rec_reg))
        else $error("request size code changed without a legal write");

    chk_gen_write: assert property ( // R9
        wr_opts && pstrb[`LANE_GEN] && !gen_inc
        |=> gen_reg == $past(pwdata[`GEN_MSB:`GEN_LSB]))
        else $error("generation counter not written");

    chk_pend_set: assert property ( // R9
        rom_changed |=> pend_reg)
        else $error("rom change not remembered");

    chk_pend_clear: assert property ( // R9
        (bus_reset || soft_rst) && !rom_changed |=> !pend_reg)
        else $error("rom change pending not cleared");

    chk_pend_hold: assert property ( // R9
        !rom_changed && !bus_reset && !soft_rst |=> $stable(pend_reg))
        else $error("rom change pending moved without cause");

    chk_link_write: assert property ( // R1
        wr_ctrl && pstrb[`LANE_CTRL] && !soft_rst
        |=> link_active_control == $past(pwdata[`CTRL_LINK_BIT]))
        else $error("link active control not written");

    chk_flags_hold: assert property ( // R1
        !(wr_opts && pstrb[`LANE_FLAGS]) && !soft_rst
        |=> $stable(bus_info_quadlet[`FLAGS_MSB:`FLAGS_LSB]))
        else $error("capability flags changed without a write");

    chk_speed_read: assert property ( // R10
        setup && !pwrite && hit_opts |=> prdata[`SPD_MSB:`SPD_LSB] == `LINK_SPEED)
        else $error("link speed code read back wrong");

    chk_ack_cause: assert property ( // R8
        ack_type_error |-> $past(blk_wr_valid))
        else $error("type error ack without a block write");

    chk_soft_clears: assert property ( // R6
        soft_rst |=> (flags_reg == '0) && (acc_reg == '0) && !link_active_control)
        else $error("software reset left fields set");

    chk_idle_quiet: assert property (
        !psel |-> !pready && !pslverr)
        else $error("bus answer without a selected transfer");

    chk_unmapped_zero: assert property ( // R3
        setup && bad_addr && !pwrite |=> prdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    cov_write_opts: cover property (wr_opts && pstrb == 4'hf);
    cov_gen_wrap: cover property (gen_reg == 2'h3 && gen_inc);
    cov_soft_reset: cover property (soft_rst);
    cov_link_on: cover property ($rose(link_active_control));
endmodule
`default_nettype wire

// ### logic/bus_options_regs.svh
// offsets, field positions and reset values of the bus options register bank
`ifndef BUS_OPTIONS_REGS_SVH
`define BUS_OPTIONS_REGS_SVH

`define ADDR_BUS_OPTS   12'h020
`define ADDR_LINK_CTRL  12'h050

`define FLAGS_MSB       31
`define FLAGS_LSB       27
`define PMC_BIT         27
`define ACC_MSB         23
`define ACC_LSB         16
`define MAXREC_MSB      15
`define MAXREC_LSB      12
`define GEN_MSB         7
`define GEN_LSB         6
`define SPD_MSB         2
`define SPD_LSB         0

`define RSVD_MASK       32'h0700_0f38
`define LINK_SPEED      3'h2
`define MAXREC_RESET    4'ha
`define MAXREC_MIN      4'h8
`define GEN_ZERO        2'h0

`define CTRL_LINK_BIT   17
`define CTRL_SRST_BIT   16
`define CTRL_PEND_BIT   0

`define LANE_FLAGS      3
`define LANE_ACC        2
`define LANE_MAXREC     1
`define LANE_GEN        0
`define LANE_CTRL       2

`endif

// ### logic/request_size_check.sv
// oversized block write detection against the request size code
`include "bus_options_regs.svh"
`default_nettype none
module request_size_check
    import bus_options_pkg::*;
#(
    parameter int LEN_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire max_rec_t         max_rec,
    input  wire logic             blk_wr_valid,
    input  wire logic [LEN_W-1:0] blk_wr_len,
    output logic                  ack_type_error
);

    // byte count is two to the power of code plus one
    function automatic logic [16:0] rec_bytes(input max_rec_t code);
        logic [4:0] exp_v;
        exp_v = {1'b0, code} + 5'h01;
        rec_bytes = 17'h00001 << exp_v;
    endfunction

    logic [16:0] limit_bytes;
    logic        too_long;
    logic        ack_reg;
    logic        ack_next;

    assign limit_bytes    = rec_bytes(max_rec);
    assign too_long       = 17'(blk_wr_len) > limit_bytes;
    assign ack_next       = blk_wr_valid & too_long; // R8
    assign ack_type_error = ack_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= ack_next;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_oversize_ack_raised: assert property ( // R8
        blk_wr_valid && (17'(blk_wr_len) > (17'h00001 << ({1'b0, max_rec} + 5'h01)))
        |=> ack_type_error)
        else $error("oversized block write not flagged");

    chk_legal_len_quiet: assert property ( // R8
        !(blk_wr_valid && too_long) |=> !ack_type_error)
        else $error("type error raised without oversized write");

    cov_oversize: cover property (blk_wr_valid && too_long);
endmodule
`default_nettype wire

// ### sim/bus_options_register_test.sv
// self-checking bench for the bus options register bank
`default_nettype none
module bus_options_register_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        req = 1'h0, rom_changed = 1'h0, bus_reset = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [15:0] req_len = 16'h0;
    logic [31:0] prdata, quad, rom_quad, rd;
    logic [15:0] blk_wr_len;
    logic        pready, pslverr, blk_wr_valid, link_active_control, ack_type_error, err;
    logic [3:0]  m;
    int          failures = 0;
    int          n_tests = 0;

    always #20 pclk = ~pclk;

    bus_options_register uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rom_changed(rom_changed), .bus_reset(bus_reset), .blk_wr_valid(blk_wr_valid),
        .blk_wr_len(blk_wr_len), .bus_info_quadlet(quad),
        .link_active_control(link_active_control), .ack_type_error(ack_type_error));

    remote_node_model node (.pclk(pclk), .presetn(presetn), .req(req), .req_len(req_len),
        .bus_info_quadlet(quad), .blk_wr_valid(blk_wr_valid), .blk_wr_len(blk_wr_len),
        .rom_quad(rom_quad));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic rdx(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'h0, a, 32'h0, 4'h0);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, a != 12'h020 && a != 12'h050});
    endtask

    task automatic pulse(input logic r, input logic b);
        rom_changed <= r;
        bus_reset <= b;
        @(posedge pclk);
        rom_changed <= 1'h0;
        bus_reset <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic blk(input logic [15:0] len, input logic exp);
        req <= 1'h1;
        req_len <= len;
        @(posedge pclk);
        req <= 1'h0;
        @(posedge pclk);
        @(negedge pclk);
        chk({31'h0, ack_type_error}, {31'h0, exp});
        @(negedge pclk);
        chk({31'h0, ack_type_error}, 32'h0);
        @(posedge pclk);
    endtask

    initial begin
        repeat (4000) @(posedge pclk);
        failures++;
        print_verdict;
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rdx(12'h020, 32'h0000_a002);
        chk(rom_quad, 32'h0000_a002);
        xfer(1'h1, 12'h020, 32'hffff_ffff, 4'hf);
        rdx(12'h020, 32'hf8ff_f0c2);
        chk(rom_quad, 32'hf8ff_f0c2);
        m = 4'hf;
        for (int c = 0; c < 16; c++) begin
            xfer(1'h1, 12'h020, {16'h0, c[3:0], 12'h0}, 4'h2);
            if (c >= 8) m = c[3:0];
            rdx(12'h020, {16'hf8ff, m, 12'h0c2});
        end
        for (int i = 0; i < 2; i++) begin
            m = (i == 0) ? 4'ha : 4'h8;
            xfer(1'h1, 12'h020, {16'h0, m, 12'h0}, 4'h2);
            blk(16'h1 << (m + 4'h1), 1'h0);
            blk((16'h1 << (m + 4'h1)) + 16'h1, 1'h1);
        end
        pulse(1'h1, 1'h0);
        rdx(12'h050, 32'h0000_0001);
        pulse(1'h0, 1'h1);
        rdx(12'h020, 32'hf8ff_8002);
        pulse(1'h0, 1'h1);
        rdx(12'h020, 32'hf8ff_8002);
        pulse(1'h1, 1'h0);
        pulse(1'h0, 1'h1);
        rdx(12'h020, 32'hf8ff_8042);
        xfer(1'h1, 12'h050, 32'h0002_0000, 4'h4);
        chk({31'h0, link_active_control}, 32'h1);
        rdx(12'h050, 32'h0002_0000);
        xfer(1'h1, 12'h050, 32'h0001_0000, 4'h4);
        rdx(12'h020, 32'h0000_8002);
        chk({31'h0, link_active_control}, 32'h0);
        rdx(12'h040, 32'h0);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rdx(12'h020, 32'h0000_a002);
        chk(rom_quad, 32'h0000_a002);
        print_verdict;
    end
endmodule
`default_nettype wire

// ### sim/remote_node_model.sv
// remote node model: issues block writes and reads the bus information quadlet
`default_nettype none
module remote_node_model #(
    parameter int LEN_W = 16
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             req,
    input  wire logic [LEN_W-1:0] req_len,
    input  wire logic [31:0]      bus_info_quadlet,
    output logic                  blk_wr_valid,
    output logic      [LEN_W-1:0] blk_wr_len,
    output logic      [31:0]      rom_quad
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_wr_valid <= 1'h0;
            blk_wr_len   <= '0;
            rom_quad     <= 32'h0;
        end else begin
            blk_wr_valid <= req;
            blk_wr_len   <= req ? req_len : ~blk_wr_len;
            rom_quad     <= bus_info_quadlet;
        end
    end
endmodule
`default_nettype wire
